// [include/sse_defs.vh]
`ifndef SSE_DEFS_VH
`define SSE_DEFS_VH

// apb register byte offsets
`define SSE_CTRL_OFF      12'h000
`define SSE_STATUS_OFF    12'h004
`define SSE_SRC_OFF       12'h008
`define SSE_BUSDATA_OFF   12'h00c
`define SSE_DRVEN_OFF     12'h010
`define SSE_INPUTS_OFF    12'h014
`define SSE_START_OFF     12'h018
`define SSE_TABLE_BASE    2'b01
`define SSE_WORDS         4
`define SSE_ENTRIES       252

// control register fields
`define SSE_CTRL_PROG_BIT 0
`define SSE_CTRL_JUMP_BIT 1

// reset values
`define SSE_CTRL_RST      1'b0
`define SSE_SRC_RST       20'h00000
`define SSE_BUSDATA_RST   10'h000
`define SSE_DRVEN_RST     10'h000
`define SSE_START_RST     6'h00

// state definition word 0
`define SSE_W0_OUT_LSB    0
`define SSE_W0_SEL_LSB    10
`define SSE_W0_LVL_BIT    14
`define SSE_W0_NEXT_LSB   15
// state definition word 1
`define SSE_W1_MASK_LSB   0
`define SSE_W1_EXP_LSB    10
`define SSE_W1_WARN_BIT   20
`define SSE_W1_NEXT_LSB   21
// state definition word 2
`define SSE_W2_DLY_LSB    0
`define SSE_W2_NEXT_LSB   16
`define SSE_W2_EN_BIT     22
`define SSE_W2_WARN_BIT   23
// state definition word 3
`define SSE_W3_TOUT_LSB   0

// sequence input select codes
`define SSE_SEL_WARN      4'ha

// driver source codes
`define SSE_SRC_ENGINE    2'b00
`define SSE_SRC_BUS       2'b01
`define SSE_SRC_CLK       2'b10

// phases
`define SSE_PH_OFF        3'd0
`define SSE_PH_WEAK       3'd1
`define SSE_PH_LOAD       3'd2
`define SSE_PH_FETCH      3'd3
`define SSE_PH_RUN        3'd4

// timing
`define SSE_CLK_NS        20
`define SSE_TICK_NS       10000
`define SSE_TICK_CYC      (`SSE_TICK_NS / `SSE_CLK_NS)
`define SSE_FETCH_NS      20000
// the exit decision, the latch and the output flop share the same 20 us budget
`define SSE_FETCH_CYC     ((`SSE_FETCH_NS / `SSE_CLK_NS) - 4)
`define SSE_OSC_NS        10000
`define SSE_OSC_HALF_CYC  ((`SSE_OSC_NS / 2) / `SSE_CLK_NS)

`endif

// [design/sse_top.v]
`timescale 1ns/10ps
`include "sse_defs.vh"
// Overview of operation
// R1 - unprogrammed device: all config zero, outputs weakly pulled to ground
// R2 - below low supply level outputs float; between levels weak pull-down
// R3 - above upper level a programmed device loads config, then outputs follow it
// R4 - up to 63 programmable state definitions
// R5 - each state watches the ten supply fault detector signals
// R6 - any state may jump directly to any programmed state index
// R7 - three exits per state: sequence, monitor, timeout
// R8 - sequence and timeout delays per state, reloaded on every state change
// R9 - the ten driver levels come from the state and hold while it lasts
// R10 - a state transition completes under 20 us definition fetch
// R11 - warnings ORed into one signal feeding all three exit blocks
// R12 - bus jump command forces an advance via sequence or timeout exit
// R13 - sequence exit watches one selected input; delay 10 us to 400 ms
// R14 - input must hold for the whole delay; any change restarts timer
// R15 - monitor exit is a wide OR of selected input deviations
// R16 - monitor exit has no delay; only the fetch latency applies
// R17 - timeout exit fires when progress missing after 100 us to 400 ms
// R18 - state driver levels apply on entry before exits are evaluated; here exits look one cycle before the output flop drives the levels
// R19 - each driver picks engine, bus value, or 100 kHz clock as source
// R20 - simultaneous exits: monitor first, then timeout, then sequence
// R21 - timeout counter starts at entry on a fixed time base, cleared on change
module sse_top #(
  parameter NUM_OUT = 10,
  parameter NUM_IN  = 10,
  parameter NUM_WRN = 6
) (
  input  wire                 pclk,           // apb clock, 50 MHz
  input  wire                 presetn,        // asynchronous reset, active low
  input  wire                 psel,           // apb select
  input  wire                 penable,        // apb enable
  input  wire                 pwrite,         // apb direction
  input  wire [11:0]          paddr,          // apb byte address
  input  wire [31:0]          pwdata,         // apb write data
  output reg  [31:0]          prdata,         // apb read data
  output wire                 pready,         // apb ready
  output wire                 pslverr,        // apb error on unmapped address
  input  wire                 supply_low_ok,  // supply above lower startup level
  input  wire                 supply_high_ok, // supply above upper startup level
  input  wire [NUM_IN-1:0]    sfd_status,     // supply fault detector outputs
  input  wire [NUM_WRN-1:0]   warn_in,        // limit and secondary monitor warnings
  output reg  [NUM_OUT-1:0]   pdo_out,        // driver output data
  output reg  [NUM_OUT-1:0]   pdo_oe,         // driver output enable
  output reg  [NUM_OUT-1:0]   pdo_pulldown    // weak pull-down enable
);

  // synchronisers for the supply level, fault detector and warning inputs
  reg  [NUM_IN+NUM_WRN+1:0] sync1;
  reg  [NUM_IN+NUM_WRN+1:0] sync2;
  wire [NUM_IN-1:0]         supply_fault_detector;
  wire                      warn;
  wire                      sup_low;
  wire                      sup_high;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= {(NUM_IN+NUM_WRN+2){1'b0}};
      sync2 <= {(NUM_IN+NUM_WRN+2){1'b0}};
    end else begin
      sync1 <= {supply_high_ok, supply_low_ok, warn_in, sfd_status};
      sync2 <= sync1;
    end
  end

  assign supply_fault_detector      = sync2[NUM_IN-1:0]; // R5
  assign warn     = |sync2[NUM_IN+NUM_WRN-1:NUM_IN]; // R11
  assign sup_low  = sync2[NUM_IN+NUM_WRN];
  assign sup_high = sync2[NUM_IN+NUM_WRN+1];

  // configuration registers
  reg                 cfg_prog;
  reg                 jump_pend;
  reg  [2*NUM_OUT-1:0] src_sel;
  reg  [NUM_OUT-1:0]  bus_data;
  reg  [NUM_OUT-1:0]  drv_en;
  reg  [5:0]          start_idx;
  reg  [31:0]         tbl [0:`SSE_ENTRIES-1]; // R4

  // engine state
  reg  [2:0]  phase;
  reg  [2:0]  next_phase;
  reg  [5:0]  cur_idx;
  reg  [9:0]  fetch_cnt;
  reg         cfg_latched;
  reg  [31:0] d0;
  reg  [31:0] d1;
  reg  [31:0] d2;
  reg  [31:0] d3;
  reg  [8:0]  tick_cnt;
  reg  [15:0] seq_cnt;
  reg  [15:0] tout_cnt;
  reg  [7:0]  osc_cnt;
  reg         osc;

  // apb decode; slave never waits
  wire        acc      = psel & penable;
  wire        setup    = psel & ~penable;
  wire        in_tbl   = (paddr[11:10] == `SSE_TABLE_BASE) && (paddr[9:4] != 6'h3f);
  wire [7:0]  tbl_idx  = paddr[9:2];
  wire        is_ctrl  = (paddr == `SSE_CTRL_OFF);
  wire        is_stat  = (paddr == `SSE_STATUS_OFF);
  wire        is_src   = (paddr == `SSE_SRC_OFF);
  wire        is_bus   = (paddr == `SSE_BUSDATA_OFF);
  wire        is_drv   = (paddr == `SSE_DRVEN_OFF);
  wire        is_inp   = (paddr == `SSE_INPUTS_OFF);
  wire        is_start = (paddr == `SSE_START_OFF);
  wire        mapped   = in_tbl | is_ctrl | is_stat | is_src | is_bus | is_drv | is_inp | is_start;
  wire        wr       = acc & pwrite & mapped;
  wire        jump_wr  = wr & is_ctrl & pwdata[`SSE_CTRL_JUMP_BIT];

  // unmapped accesses are refused; a write there changes nothing
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // read data is registered in the setup cycle so it is stable in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      if (in_tbl)
        prdata <= tbl[tbl_idx];
      else if (is_ctrl)
        prdata <= {30'h00000000, jump_pend, cfg_prog};
      else if (is_stat)
        prdata <= {20'h00000, cfg_latched, phase, 2'b00, cur_idx};
      else if (is_src)
        prdata <= {12'h000, src_sel};
      else if (is_bus)
        prdata <= {22'h000000, bus_data};
      else if (is_drv)
        prdata <= {22'h000000, drv_en};
      else if (is_inp)
        prdata <= {21'h000000, warn, supply_fault_detector};
      else if (is_start)
        prdata <= {26'h0000000, start_idx};
      else
        prdata <= 32'h00000000;
    end
  end

  // configuration writes; everything clears to zero at reset
  integer k;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_prog  <= `SSE_CTRL_RST; // R1
      src_sel   <= `SSE_SRC_RST;
      bus_data  <= `SSE_BUSDATA_RST;
      drv_en    <= `SSE_DRVEN_RST;
      start_idx <= `SSE_START_RST;
      for (k = 0; k < `SSE_ENTRIES; k = k + 1)
        tbl[k] <= 32'h00000000; // R1
    end else if (wr) begin
      if (is_ctrl)
        cfg_prog <= pwdata[`SSE_CTRL_PROG_BIT];
      if (is_src)
        src_sel <= pwdata[2*NUM_OUT-1:0];
      if (is_bus)
        bus_data <= pwdata[NUM_OUT-1:0];
      if (is_drv)
        drv_en <= pwdata[NUM_OUT-1:0];
      if (is_start)
        start_idx <= pwdata[5:0];
      if (in_tbl)
        tbl[tbl_idx] <= pwdata;
    end
  end

  // fixed 10 us time base shared by both delay timers
  // it is not aligned to state entry, so delays are exact only to one tick
  wire tick = (tick_cnt == `SSE_TICK_CYC - 1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tick_cnt <= 9'h000;
    else if (tick)
      tick_cnt <= 9'h000;
    else
      tick_cnt <= tick_cnt + 9'h001;
  end

  // 100 kHz on-chip clock for drivers that select it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt <= 8'h00;
      osc     <= 1'b0;
    end else if (osc_cnt == `SSE_OSC_HALF_CYC - 1) begin
      osc_cnt <= 8'h00;
      osc     <= ~osc; // R19
    end else begin
      osc_cnt <= osc_cnt + 8'h01;
    end
  end

  // exit evaluation on the latched definition
  wire [3:0]        seq_sel  = d0[`SSE_W0_SEL_LSB +: 4];
  wire              seq_on   = (seq_sel <= `SSE_SEL_WARN);
  wire              seq_in   = (seq_sel == `SSE_SEL_WARN) ? warn : (seq_on ? supply_fault_detector[seq_sel] : 1'b0); // R11
  wire              seq_cond = seq_on & (seq_in == d0[`SSE_W0_LVL_BIT]); // R13
  wire              seq_fire = seq_cond & (seq_cnt >= d2[`SSE_W2_DLY_LSB +: 16]); // R14
  wire [NUM_IN-1:0] dev      = d1[`SSE_W1_MASK_LSB +: 10] & (supply_fault_detector ^ d1[`SSE_W1_EXP_LSB +: 10]);
  wire              mon_fire = (|dev) | (d1[`SSE_W1_WARN_BIT] & warn); // R15 R16
  wire              tout_on  = d2[`SSE_W2_EN_BIT];
  wire              tout_fire = tout_on & ((tout_cnt >= d3[`SSE_W3_TOUT_LSB +: 16]) |
                                           (d2[`SSE_W2_WARN_BIT] & warn)); // R17 R11
  wire              run      = (phase == `SSE_PH_RUN);
  // jump follows the sequence exit, or the timeout exit where no sequence is set
  wire              jump_seq  = jump_pend & seq_on; // R12
  wire              jump_tout = jump_pend & ~seq_on & tout_on; // R12
  reg               take;
  reg  [5:0]        target;

  // exit arbitration; all three exits are looked at in every run cycle
  // monitor goes first since a rail out of tolerance cannot wait behind a delay
  always @* begin
    take   = 1'b0;
    target = cur_idx;
    if (run) begin
      if (mon_fire) begin
        take   = 1'b1; // R20
        target = d1[`SSE_W1_NEXT_LSB +: 6]; // R6 R7
      end else if (tout_fire | jump_tout) begin
        take   = 1'b1; // R20
        target = d2[`SSE_W2_NEXT_LSB +: 6]; // R6
      end else if (seq_fire | jump_seq) begin
        take   = 1'b1; // R20
        target = d0[`SSE_W0_NEXT_LSB +: 6]; // R6
      end
    end
  end

  // jump request stays pending until an exit is taken or the engine leaves run; a new write wins over the clear
  // a jump with neither sequence nor timeout exit is dropped, never carried into a later state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      jump_pend <= 1'b0;
    else if (jump_wr)
      jump_pend <= 1'b1;
    else if (take | ~run | ~(seq_on | tout_on))
      jump_pend <= 1'b0;
  end

  // power-up and sequencing phase control
  always @* begin
    next_phase = phase;
    case (phase)
      `SSE_PH_OFF:   if (sup_low) next_phase = `SSE_PH_WEAK; // R2
      `SSE_PH_WEAK:  if (sup_high & cfg_prog) next_phase = `SSE_PH_LOAD; // R3
      `SSE_PH_LOAD:  next_phase = `SSE_PH_FETCH;
      `SSE_PH_FETCH: if (fetch_cnt == `SSE_FETCH_CYC) next_phase = `SSE_PH_RUN; // R10
      `SSE_PH_RUN:   if (take) next_phase = `SSE_PH_FETCH;
      default:       next_phase = `SSE_PH_OFF;
    endcase
    if (!sup_low)
      next_phase = `SSE_PH_OFF; // R2
    else if (!sup_high && phase != `SSE_PH_OFF)
      next_phase = `SSE_PH_WEAK;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase       <= `SSE_PH_OFF;
      cur_idx     <= 6'h00;
      fetch_cnt   <= 10'h000;
      cfg_latched <= 1'b0;
      d0          <= 32'h00000000;
      d1          <= 32'h00000000;
      d2          <= 32'h00000000;
      d3          <= 32'h00000000;
    end else begin
      phase <= next_phase;
      if (next_phase == `SSE_PH_OFF || next_phase == `SSE_PH_WEAK)
        cfg_latched <= 1'b0;
      if (phase == `SSE_PH_LOAD)
        cur_idx <= start_idx;
      if (phase == `SSE_PH_RUN && take)
        cur_idx <= target; // R6
      if (phase == `SSE_PH_FETCH)
        fetch_cnt <= fetch_cnt + 10'h001;
      else
        fetch_cnt <= 10'h000;
      // definition and its levels latch at the end of the fetch, on the same edge that lets the exits look
      // the setup counts as latched only once the first definition is in,
      // so the drivers stay weak while it is still being fetched
      if (phase == `SSE_PH_FETCH && next_phase == `SSE_PH_RUN) begin
        cfg_latched <= 1'b1; // R3
        d0 <= tbl[{cur_idx, 2'b00}]; // R18 R9
        d1 <= tbl[{cur_idx, 2'b01}];
        d2 <= tbl[{cur_idx, 2'b10}];
        d3 <= tbl[{cur_idx, 2'b11}];
      end
    end
  end

  // delay timers restart whenever the engine is not sitting in a state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_cnt  <= 16'h0000;
      tout_cnt <= 16'h0000;
    end else if (!run || take) begin
      seq_cnt  <= 16'h0000; // R8
      tout_cnt <= 16'h0000; // R21
    end else begin
      if (!seq_cond)
        seq_cnt <= 16'h0000; // R14
      else if (tick && seq_cnt != 16'hffff)
        seq_cnt <= seq_cnt + 16'h0001;
      if (tick && tout_cnt != 16'hffff)
        tout_cnt <= tout_cnt + 16'h0001; // R21
    end
  end

  // per-driver source select and pin drive
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g = g + 1) begin : g_drv
      wire [1:0] s = src_sel[2*g +: 2];
      wire       v = (s == `SSE_SRC_BUS) ? bus_data[g] :
                     (s == `SSE_SRC_CLK) ? osc : d0[`SSE_W0_OUT_LSB + g]; // R19 R9
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pdo_out[g]      <= 1'b0;
          pdo_oe[g]       <= 1'b0;
          pdo_pulldown[g] <= 1'b0;
        end else if (phase == `SSE_PH_OFF) begin
          pdo_out[g]      <= 1'b0; // R2
          pdo_oe[g]       <= 1'b0;
          pdo_pulldown[g] <= 1'b0;
        end else if (!cfg_latched) begin
          pdo_out[g]      <= 1'b0; // R2 R1
          pdo_oe[g]       <= 1'b0;
          pdo_pulldown[g] <= 1'b1;
        end else begin
          pdo_out[g]      <= v; // R3
          pdo_oe[g]       <= drv_en[g];
          pdo_pulldown[g] <= ~drv_en[g]; // R1
        end
      end
    end
  endgenerate

endmodule

// [bench/sse_top_properties.sv]
`timescale 1ns/10ps
module sse_top_chk #(
  parameter NUM_OUT = 10
) (
  input wire               pclk,           // apb clock
  input wire               presetn,        // reset, active low
  input wire               psel,           // select
  input wire               penable,        // enable
  input wire               pwrite,         // direction
  input wire [11:0]        paddr,          // byte address
  input wire [31:0]        prdata,         // read data
  input wire               pready,         // ready
  input wire               pslverr,        // error
  input wire               supply_low_ok,  // lower level
  input wire               supply_high_ok, // upper level
  input wire [NUM_OUT-1:0] pdo_out,        // driver data
  input wire [NUM_OUT-1:0] pdo_oe,         // drive enable
  input wire [NUM_OUT-1:0] pdo_pulldown    // weak pull-down
);
  localparam [NUM_OUT-1:0] all_ones = {NUM_OUT{1'b1}};
  // aligned access phase, split by whether the address decodes
  wire acc      = psel & penable & (paddr[1:0] == 2'b00);
  wire unmapped = (paddr[11:4] == 8'h7f) | ((paddr[11:10] != 2'b01) & (paddr >= 12'h01c));
  logic [NUM_OUT-1:0] prev_out;
  logic [10:0]        gap;
  logic               excused;
  logic               free_run;
  wire                chg = pdo_out != prev_out;
  // cycles since the last level change; writes and supply moves excuse a quick change,
  // and a source write may select the free clock, so the check stands down after one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_out <= {NUM_OUT{1'b0}};
      gap      <= 11'h000;
      excused  <= 1'b1;
      free_run <= 1'b0;
    end else begin
      prev_out <= pdo_out;
      gap      <= chg ? 11'h000 : ((gap == 11'h7ff) ? gap : gap + 11'h001);
      excused  <= (excused & ~chg) | (psel & pwrite) | $changed(supply_high_ok) | $changed(supply_low_ok);
      free_run <= free_run | (psel & pwrite & (paddr == 12'h008));
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_floating;
    !supply_low_ok [*5];
  endsequence
  sequence s_weak_hold;
    (supply_low_ok && !supply_high_ok) [*6];
  endsequence

  chk_wake_quiet: assert property ($rose(presetn) |-> !(|(pdo_oe | pdo_pulldown)))
    else $error("outputs active right after reset");
  chk_float_low: assert property (s_floating |-> !(|(pdo_oe | pdo_pulldown)))
    else $error("outputs not floating below lower level");
  chk_weak_mid: assert property (s_weak_hold |-> pdo_pulldown == all_ones && !(|pdo_oe))
    else $error("outputs not weakly pulled low between levels");
  chk_drive_excl: assert property (!(|(pdo_oe & pdo_pulldown)))
    else $error("driver and pull-down on together");
  chk_fetch_gap: assert property (chg && !excused && !free_run |-> gap >= 11'h3de)
    else $error("levels changed faster than a definition fetch");
  chk_ready_now: assert property (psel && !penable |=> pready)
    else $error("ready missing in access phase");
  chk_err_unmapped: assert property (acc && unmapped |-> pslverr)
    else $error("unmapped address not refused");
  chk_err_mapped: assert property (acc && !unmapped |-> !pslverr)
    else $error("mapped address refused");
  chk_read_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
endmodule

// [bench/sse_supply_model.sv]
`timescale 1ns/10ps
module sse_supply_model (
  input  wire       pclk,       // system clock
  input  wire [9:0] pdo_out,    // regulator enables
  input  wire [9:0] pdo_oe,     // enable driven
  input  wire [9:0] fault,      // commanded collapse
  input  wire [9:0] extra,      // forced good
  output reg  [9:0] sfd_status  // detector outputs
);
  // a rail reports good a cycle after its enable is driven high; a weak pull-down keeps it off
  initial sfd_status = 10'h000;
  always @(posedge pclk) begin
    sfd_status <= ((pdo_out & pdo_oe) | extra) & ~fault;
  end
endmodule

// [bench/sse_top_tb.sv]
`timescale 1ns/10ps
module sse_top_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, supply_low_ok = 1'b0;
  logic        supply_high_ok = 1'b0, pready, pslverr, rerr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [9:0]  fault = 10'h000, extra = 10'h000, sfd_status, pdo_out, pdo_oe, pdo_pulldown;
  logic [5:0]  warn_in = 6'h00;
  int          err_count, cmp_count, n;

  // 50 MHz clock
  always #10 pclk = ~pclk;

  sse_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_low_ok(supply_low_ok),
    .supply_high_ok(supply_high_ok), .sfd_status(sfd_status), .warn_in(warn_in), .pdo_out(pdo_out),
    .pdo_oe(pdo_oe), .pdo_pulldown(pdo_pulldown));
  sse_supply_model u_sup (.pclk(pclk), .pdo_out(pdo_out), .pdo_oe(pdo_oe), .fault(fault), .extra(extra),
    .sfd_status(sfd_status));

  task automatic check_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic check_pins(input string nm, input logic [9:0] exp, input logic [9:0] got);
    check_word(nm, {22'h0, exp}, {22'h0, got});
  endtask
  // one transfer; held until ready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_state(input logic [7:0] s, input logic [31:0] w0, w1, w2, w3);
    apb(1'b1, {s, 4'h0} + 12'h400, w0);
    apb(1'b1, {s, 4'h4} + 12'h400, w1);
    apb(1'b1, {s, 4'h8} + 12'h400, w2);
    apb(1'b1, {s, 4'hc} + 12'h400, w3);
  endtask
  // bounded wait, sampled mid-cycle where the outputs have settled
  task automatic wait_pdo(input logic [9:0] exp, input int lim);
    n = 0;
    @(negedge pclk);
    while (pdo_out !== exp && n < lim) begin
      n++;
      @(negedge pclk);
    end
    check_pins("pdo_out", exp, pdo_out);
  endtask

  task automatic t_reset;
    logic [11:0] regs [5] = '{12'h000, 12'h008, 12'h00c, 12'h010, 12'h018};
    check_pins("quiet", 10'h000, pdo_oe | pdo_pulldown);
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0);
      check_word("reg", 32'h0, rdat);
    end
    apb(1'b0, 12'h01c, 32'h0);
    check_word("unmapped", 32'h1, {rdat[30:0], rerr});
    apb(1'b1, 12'h7f0, 32'hffffffff);
    apb(1'b0, 12'h7f0, 32'h0);
    check_word("state63", 32'h1, {rdat[30:0], rerr});
  endtask
  task automatic t_weak;
    @(posedge pclk);
    supply_low_ok <= 1'b1;
    repeat (8) @(posedge pclk);
    check_pins("weak", 10'h3ff, pdo_pulldown & ~pdo_oe);
    supply_high_ok <= 1'b1;
    repeat (1100) @(posedge pclk);
    check_pins("unprog", 10'h3ff, pdo_pulldown & ~pdo_oe);
    supply_high_ok <= 1'b0;
  endtask
  // states 0..5 with next targets out of order
  task automatic t_prog;
    set_state(8'h00, 32'h0000c001, 32'h0, 32'h4, 32'h0);
    set_state(8'h01, 32'h00014803, 32'h00800401, 32'h0, 32'h0);
    set_state(8'h02, 32'h0001d407, 32'h0, 32'h0, 32'h0);
    set_state(8'h03, 32'h0002e80f, 32'h0, 32'h0, 32'h0);
    set_state(8'h04, 32'h00003c10, 32'h0, 32'h00420000, 32'h3);
    set_state(8'h05, 32'h00003ea0, 32'h0, 32'h0, 32'h0);
    apb(1'b1, 12'h010, 32'h3ff);
    apb(1'b1, 12'h000, 32'h1);
    @(posedge pclk);
    supply_high_ok <= 1'b1;
    wait_pdo(10'h001, 1300);
    check_pins("drive", 10'h3ff, pdo_oe);
  endtask
  // a glitch on the watched rail must restart the sequence delay
  task automatic t_seq;
    repeat (1200) @(posedge pclk);
    fault[0] <= 1'b1;
    repeat (5) @(posedge pclk);
    fault[0] <= 1'b0;
    repeat (2200) @(posedge pclk);
    check_pins("held", 10'h001, pdo_out);
    wait_pdo(10'h003, 2500);
  endtask
  // monitor and sequence fire together; monitor wins
  task automatic t_prio;
    @(posedge pclk);
    fault[0] <= 1'b1;
    extra[2] <= 1'b1;
    wait_pdo(10'h010, 1100);
    // partner one cycle, synchroniser two, then the transition in under 1000 cycles
    check_word("mon_lat", 32'h1, {31'h0, n < 1003});
    @(posedge pclk);
    fault[0] <= 1'b0;
    extra[2] <= 1'b0;
  endtask
  task automatic t_tout;
    wait_pdo(10'h007, 3300);
    check_word("tout_win", 32'h1, {31'h0, n >= 1900 && n <= 3100});
  endtask
  task automatic t_jump;
    apb(1'b1, 12'h000, 32'h3);
    wait_pdo(10'h00f, 1100);
    @(posedge pclk);
    warn_in <= 6'h08;
    wait_pdo(10'h2a0, 1100);
    @(posedge pclk);
    warn_in <= 6'h00;
  endtask
  // bus-sourced driver, then loss of the upper level
  task automatic t_src;
    logic b;
    apb(1'b0, 12'h004, 32'h0);
    check_word("status", 32'hc05, rdat);
    apb(1'b0, 12'h014, 32'h0);
    check_word("inputs", 32'h2a0, rdat);
    apb(1'b1, 12'h008, 32'h9);
    apb(1'b1, 12'h00c, 32'h1);
    repeat (4) @(posedge pclk);
    check_pins("bus_src", 10'h2a1, pdo_out & 10'h3fd);
    // driver 1 runs from the 100 kHz clock: one toggle every 250 cycles
    b = pdo_out[1];
    repeat (250) @(posedge pclk);
    check_pins("clk_src", {9'h0, ~b}, {9'h0, pdo_out[1]});
    apb(1'b0, 12'h008, 32'h0);
    check_word("src", 32'h9, rdat);
    @(posedge pclk);
    supply_high_ok <= 1'b0;
    repeat (8) @(posedge pclk);
    check_pins("fallback", 10'h3ff, pdo_pulldown & ~pdo_oe);
  endtask

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_weak();
    t_prog();
    t_seq();
    t_prio();
    t_tout();
    t_jump();
    t_src();
    give_verdict();
  end
endmodule

bind sse_top sse_top_chk #(.NUM_OUT(NUM_OUT)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_low_ok(supply_low_ok),
  .supply_high_ok(supply_high_ok), .pdo_out(pdo_out), .pdo_oe(pdo_oe), .pdo_pulldown(pdo_pulldown));
